/* rtl/basu_unit.sv */
`timescale 1ns/10ps
`include "basu_defines.svh"

// Contract
// RULE1 - Four byte magnitudes add into own halves
// RULE2 - Four running sums in two accumulators' halves
// RULE3 - Half overflow saturates, never wraps
// RULE4 - Sources only pairs R1:0 or R3:2
// RULE5 - Index zero offsets first source pair
// RULE6 - Index one offsets second source pair
// RULE7 - Offset selects bytes off+3 down to off
// RULE8 - Forward: low bytes from lower register
// RULE9 - Reverse: low bytes from higher register
// RULE10 - Suppress parallel misaligned load exceptions
// RULE11 - Operations are 32-bit instructions
// RULE12 - Parallel issue only with 16-bit partners
// RULE13 - Software limits block to 32x32 pixels
// RULE14 - Unpack copies four aligned bytes out
// RULE15 - Unpack offset from index zero only
// RULE16 - Unpack places A,B and C,D lanes
// RULE17 - Unpack zero-extends bytes into half-words
// RULE18 - Unsigned bytes; lanes map to fixed halves
module basu_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Issue from decode
    input wire logic issue_valid,
    input wire basu_pkg::basu_op_t op_kind,
    input wire logic insn_len32,
    input wire logic reverse,
    input wire logic pair_a_sel,
    input wire logic pair_b_sel,
    input wire logic [`BASU_DIDX_W-1:0] dest0_idx,
    input wire logic [`BASU_DIDX_W-1:0] dest1_idx,
    // Parallel slot of the same packet
    input wire logic par_valid,
    input wire logic par_len32,
    // Register file operands
    input wire logic [`BASU_WORD_W-1:0] dreg0,
    input wire logic [`BASU_WORD_W-1:0] dreg1,
    input wire logic [`BASU_WORD_W-1:0] dreg2,
    input wire logic [`BASU_WORD_W-1:0] dreg3,
    input wire logic [`BASU_OFF_W-1:0] align_index_zero,
    input wire logic [`BASU_OFF_W-1:0] align_index_one,
    // Accumulator control
    input wire logic acc_clear,
    // Issue answers
    output logic issue_refused,
    output logic misalign_suppress,
    // Accumulator halves
    output basu_pkg::basu_half_t acc_zero_low_half,
    output basu_pkg::basu_half_t acc_zero_high_half,
    output basu_pkg::basu_half_t acc_one_low_half,
    output basu_pkg::basu_half_t acc_one_high_half,
    // Results: execute state for both operations, then unpack words and indexes
    output logic result_valid,
    output basu_pkg::basu_op_t result_op,
    output logic [`BASU_WORD_W-1:0] unpack_dest0,
    output logic [`BASU_WORD_W-1:0] unpack_dest1,
    output logic [`BASU_DIDX_W-1:0] unpack_dest0_idx,
    output logic [`BASU_DIDX_W-1:0] unpack_dest1_idx
);
    import basu_pkg::*;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [`BASU_BYTE_W-1:0] abs_diff(
        input logic [`BASU_BYTE_W-1:0] a,
        input logic [`BASU_BYTE_W-1:0] b
    );
        // Bytes are unsigned, so the larger minus the smaller never borrows
        abs_diff = (a >= b) ? a - b : b - a; // RULE1 RULE18
    endfunction : abs_diff

    function automatic basu_half_t sat_add(
        input basu_half_t acc,
        input logic [`BASU_BYTE_W-1:0] mag
    );
        logic [`BASU_HALF_W:0] sum;
        sum = {1'b0, acc} + {9'h000, mag};
        // Carry out means the half overflowed; pin it at full scale
        sat_add = sum[`BASU_HALF_W] ? `BASU_HALF_MAX : sum[`BASU_HALF_W-1:0]; // RULE3
    endfunction : sat_add

    function automatic logic [`BASU_WORD_W-1:0] pair_word(
        input logic pair_sel,
        input logic hi,
        input logic [`BASU_WORD_W-1:0] r0,
        input logic [`BASU_WORD_W-1:0] r1,
        input logic [`BASU_WORD_W-1:0] r2,
        input logic [`BASU_WORD_W-1:0] r3
    );
        // Only two pairs are encodable, so no other pair can reach the datapath
        case ({pair_sel, hi}) // RULE4
            2'h0: pair_word = r0;
            2'h1: pair_word = r1;
            2'h2: pair_word = r2;
            default: pair_word = r3;
        endcase
    endfunction : pair_word

    // ----------------------------------------
    // Issue acceptance
    // ----------------------------------------
    logic is_known_op;
    logic partner_ok;
    logic accept;
    logic saa_go;
    logic unpack_go;

    assign is_known_op = (op_kind == BASU_OP_SAA) || (op_kind == BASU_OP_UNPACK);
    // A 32-bit partner in the same packet cannot pair with this unit
    assign partner_ok = !(par_valid && par_len32); // RULE12
    assign accept = issue_valid && insn_len32 && partner_ok && is_known_op; // RULE11
    assign saa_go = accept && (op_kind == BASU_OP_SAA);
    assign unpack_go = accept && (op_kind == BASU_OP_UNPACK);
    assign issue_refused = issue_valid && !accept;
    // Parallel loads may be misaligned while this unit executes
    assign misalign_suppress = accept; // RULE10

    // ----------------------------------------
    // Operand alignment
    // ----------------------------------------
    logic [`BASU_WORD_W-1:0] a_lo;
    logic [`BASU_WORD_W-1:0] a_hi;
    logic [`BASU_WORD_W-1:0] b_lo;
    logic [`BASU_WORD_W-1:0] b_hi;
    logic [`BASU_WORD_W-1:0] aligned_a;
    logic [`BASU_WORD_W-1:0] aligned_b;

    assign a_lo = pair_word(pair_a_sel, 1'b0, dreg0, dreg1, dreg2, dreg3);
    assign a_hi = pair_word(pair_a_sel, 1'b1, dreg0, dreg1, dreg2, dreg3);
    assign b_lo = pair_word(pair_b_sel, 1'b0, dreg0, dreg1, dreg2, dreg3);
    assign b_hi = pair_word(pair_b_sel, 1'b1, dreg0, dreg1, dreg2, dreg3);

    // First pair is shared by both operations and always uses index zero
    basu_byte_align u_align_a (
        .lo_word(a_lo),
        .hi_word(a_hi),
        .reverse(reverse),
        .offset(align_index_zero), // RULE5 RULE15
        .aligned(aligned_a)
    );

    basu_byte_align u_align_b (
        .lo_word(b_lo),
        .hi_word(b_hi),
        .reverse(reverse),
        .offset(align_index_one), // RULE6
        .aligned(aligned_b)
    );

    // ----------------------------------------
    // Lane arithmetic
    // ----------------------------------------
    basu_half_t acc_r [`BASU_LANES];
    basu_half_t acc_nxt [`BASU_LANES];
    logic [`BASU_BYTE_W-1:0] lane_mag [`BASU_LANES];

    genvar g;
    generate
        for (g = 0; g < `BASU_LANES; g++) begin : g_lane
            basu_half_t base;
            assign lane_mag[g] = abs_diff(aligned_a[g*`BASU_BYTE_W +: `BASU_BYTE_W],
                                          aligned_b[g*`BASU_BYTE_W +: `BASU_BYTE_W]); // RULE1
            // A clear in the same cycle restarts the sum from zero
            assign base = acc_clear ? `BASU_HALF_RST : acc_r[g];
            assign acc_nxt[g] = sat_add(base, lane_mag[g]); // RULE1 RULE3
        end
    endgenerate

    // ----------------------------------------
    // Accumulator halves
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `BASU_LANES; i++) begin
                acc_r[i] <= `BASU_HALF_RST;
            end
        end else if (saa_go) begin
            for (int i = 0; i < `BASU_LANES; i++) begin
                acc_r[i] <= acc_nxt[i]; // RULE2
            end
        end else if (acc_clear) begin
            for (int i = 0; i < `BASU_LANES; i++) begin
                acc_r[i] <= `BASU_HALF_RST;
            end
        end
    end

    // Lane 0..3 map to zero low, zero high, one low, one high
    assign acc_zero_low_half = acc_r[0]; // RULE18
    assign acc_zero_high_half = acc_r[1];
    assign acc_one_low_half = acc_r[2];
    assign acc_one_high_half = acc_r[3];

    // ----------------------------------------
    // Unpack results
    // ----------------------------------------
    logic [`BASU_WORD_W-1:0] dest0_nxt;
    logic [`BASU_WORD_W-1:0] dest1_nxt;
    logic [`BASU_WORD_W-1:0] dest0_r;
    logic [`BASU_WORD_W-1:0] dest1_r;
    logic [`BASU_DIDX_W-1:0] dest0_idx_r;
    logic [`BASU_DIDX_W-1:0] dest1_idx_r;

    // Upper byte of each half-word is zero, so lanes read as unsigned
    assign dest0_nxt = {8'h00, aligned_a[15:8], 8'h00, aligned_a[7:0]}; // RULE16 RULE17
    assign dest1_nxt = {8'h00, aligned_a[31:24], 8'h00, aligned_a[23:16]}; // RULE16 RULE17

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dest0_r <= `BASU_WORD_RST;
            dest1_r <= `BASU_WORD_RST;
            dest0_idx_r <= `BASU_DIDX_RST;
            dest1_idx_r <= `BASU_DIDX_RST;
        end else if (unpack_go) begin
            dest0_r <= dest0_nxt; // RULE14
            dest1_r <= dest1_nxt;
            dest0_idx_r <= dest0_idx;
            dest1_idx_r <= dest1_idx;
        end
    end

    assign unpack_dest0 = dest0_r;
    assign unpack_dest1 = dest1_r;
    assign unpack_dest0_idx = dest0_idx_r;
    assign unpack_dest1_idx = dest1_idx_r;

    // ----------------------------------------
    // Execute state
    // ----------------------------------------
    basu_op_t exec_r;
    basu_op_t exec_nxt;

    always_comb begin
        case ({saa_go, unpack_go})
            2'b10: exec_nxt = BASU_OP_SAA;
            2'b01: exec_nxt = BASU_OP_UNPACK;
            default: exec_nxt = BASU_OP_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exec_r <= BASU_OP_IDLE;
        end else begin
            exec_r <= exec_nxt;
        end
    end

    assign result_valid = (exec_r != BASU_OP_IDLE);
    assign result_op = exec_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_saa_plain;
        saa_go && !acc_clear;
    endsequence

    sequence s_unpack_fwd0;
        unpack_go && !reverse && (align_index_zero == 2'h0) && !pair_a_sel;
    endsequence

    sequence s_unpack_rev0;
        unpack_go && reverse && (align_index_zero == 2'h0) && !pair_a_sel;
    endsequence

    AST_SAA_NO_DECREASE: assert property ( // RULE3
        s_saa_plain |=> (acc_zero_low_half >= $past(acc_zero_low_half))
            && (acc_one_high_half >= $past(acc_one_high_half)))
        else $error("accumulator half wrapped on overflow");

    AST_SAT_HOLDS_MAX: assert property ( // RULE3
        s_saa_plain ##0 (acc_one_low_half == `BASU_HALF_MAX) |=>
            (acc_one_low_half == `BASU_HALF_MAX))
        else $error("saturated half left full scale");

    AST_ACC_STABLE: assert property ( // RULE2
        !saa_go && !acc_clear |=> $stable(acc_zero_high_half) && $stable(acc_zero_low_half))
        else $error("accumulator changed without an operation");

    AST_SAA_EQUAL_BYTES: assert property ( // RULE1
        s_saa_plain ##0 (aligned_a == aligned_b) |=>
            $stable(acc_zero_low_half) && $stable(acc_one_high_half))
        else $error("zero difference changed an accumulator");

    AST_SAA_LANE0_ADD: assert property ( // RULE18
        s_saa_plain ##0 (acc_r[0] < 16'hFF00) |=>
            (acc_zero_low_half == $past(acc_zero_low_half) + 16'($past(lane_mag[0]))))
        else $error("lane zero did not add its magnitude");

    AST_UNPACK_ZERO_EXT: assert property ( // RULE17
        unpack_go |=> (unpack_dest0[15:8] == 8'h00) && (unpack_dest1[31:24] == 8'h00)
            && result_valid && (result_op == BASU_OP_UNPACK))
        else $error("unpack lane upper byte not zero");

    AST_UNPACK_FWD: assert property ( // RULE8
        s_unpack_fwd0 |=> (unpack_dest0[7:0] == $past(dreg0[7:0]))
            && (unpack_dest1[23:16] == $past(dreg0[31:24])))
        else $error("forward unpack took wrong bytes");

    AST_UNPACK_REV: assert property ( // RULE9
        s_unpack_rev0 |=> (unpack_dest0[7:0] == $past(dreg1[7:0])))
        else $error("reverse unpack did not swap registers");

    AST_REFUSE_PARTNER: assert property ( // RULE12
        issue_valid && par_valid && par_len32 |-> issue_refused && !misalign_suppress
            ##1 !result_valid)
        else $error("issued beside a 32-bit partner");

    AST_SUPPRESS_ONE: assert property ( // RULE10
        misalign_suppress |-> issue_valid && insn_len32 ##1 result_valid)
        else $error("suppression without an executing operation");

endmodule : basu_unit

/* rtl/basu_defines.svh */
`ifndef BASU_DEFINES_SVH
`define BASU_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define BASU_BYTE_W 8
`define BASU_HALF_W 16
`define BASU_WORD_W 32
`define BASU_OFF_W 2
`define BASU_LANES 4
`define BASU_DIDX_W 3

// ----------------------------------------
// Values and field positions
// ----------------------------------------
`define BASU_HALF_MAX 16'hFFFF
`define BASU_HALF_RST 16'h0000
`define BASU_WORD_RST 32'h0000_0000
`define BASU_DIDX_RST 3'h0
`define BASU_PAIR_R10 1'h0
`define BASU_PAIR_R32 1'h1
`define BASU_LO_LANE_LSB 0
`define BASU_HI_LANE_LSB 16

// ----------------------------------------
// Timing
// ----------------------------------------
`define BASU_RESULT_LAT 1

`endif

/* rtl/basu_pkg.sv */
package basu_pkg;

    // Operation kind, one-hot; also used as the execute-stage state
    typedef enum logic [2:0] {
        BASU_OP_IDLE = 3'b001,
        BASU_OP_SAA = 3'b010,
        BASU_OP_UNPACK = 3'b100
    } basu_op_t;

    typedef logic [15:0] basu_half_t;

endpackage : basu_pkg

/* rtl/basu_byte_align.sv */
`timescale 1ns/10ps
`include "basu_defines.svh"

module basu_byte_align #(
    parameter int WORD_W = `BASU_WORD_W,
    parameter int OFF_W = `BASU_OFF_W
) (
    // Source pair
    input wire logic [WORD_W-1:0] lo_word,
    input wire logic [WORD_W-1:0] hi_word,
    // Options
    input wire logic reverse,
    input wire logic [OFF_W-1:0] offset,
    // Result
    output logic [WORD_W-1:0] aligned
);
    import basu_pkg::*;

    logic [2*WORD_W-1:0] pair_bytes;

    // ----------------------------------------
    // Pair order and byte window
    // ----------------------------------------
    // Reverse swaps the two words so the high register feeds the low bytes
    assign pair_bytes = reverse ? {lo_word, hi_word} : {hi_word, lo_word}; // RULE8 RULE9
    // Window of four bytes starting at the offset byte
    assign aligned = pair_bytes[offset*`BASU_BYTE_W +: WORD_W]; // RULE7

endmodule : basu_byte_align

/* test/basu_decode_model.sv */
`timescale 1ns/10ps
`include "basu_defines.svh"

// ----------------------------------------
// Decode and register file model
// ----------------------------------------
module basu_decode_model (
    // Clock
    input wire logic clk,
    // Issue fields
    output basu_pkg::basu_op_t op_kind,
    output logic issue_valid,
    output logic insn_len32,
    output logic par_valid,
    output logic par_len32,
    output logic acc_clear,
    output logic reverse,
    output logic pair_a_sel,
    output logic pair_b_sel,
    output logic [`BASU_DIDX_W-1:0] dest0_idx,
    output logic [`BASU_DIDX_W-1:0] dest1_idx,
    // Register file
    output logic [`BASU_WORD_W-1:0] dreg0,
    output logic [`BASU_WORD_W-1:0] dreg1,
    output logic [`BASU_WORD_W-1:0] dreg2,
    output logic [`BASU_WORD_W-1:0] dreg3,
    output logic [`BASU_OFF_W-1:0] align_index_zero,
    output logic [`BASU_OFF_W-1:0] align_index_one
);
    import basu_pkg::*;

    initial begin
        op_kind = BASU_OP_IDLE;
        {issue_valid, insn_len32, par_valid, par_len32, acc_clear} = 5'h00;
        {reverse, pair_a_sel, pair_b_sel} = 3'h0;
        {dreg3, dreg2, dreg1, dreg0} = 128'h0;
        {align_index_one, align_index_zero, dest1_idx, dest0_idx} = 10'h000;
    end

    // One packet per edge; long sums past a 32x32 block are the caller's choice
    task automatic send(input basu_op_t k, input logic [7:0] c, input logic [127:0] r,
            input logic [3:0] ix, input logic [5:0] dx);
        @(posedge clk);
        op_kind <= k;
        {issue_valid, insn_len32, par_valid, par_len32} <= c[7:4];
        {acc_clear, reverse} <= c[3:2];
        {pair_a_sel, pair_b_sel} <= c[1:0];
        {dreg3, dreg2, dreg1, dreg0} <= r;
        {align_index_one, align_index_zero} <= ix;
        {dest1_idx, dest0_idx} <= dx;
    endtask : send
endmodule : basu_decode_model

/* test/byte_align_sad_unpack_unit_tb.sv */
`timescale 1ns/10ps

module byte_align_sad_unpack_unit_tb;
    import basu_pkg::*;

    // ----------------------------------------
    // Signals and model state
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic issue_valid, insn_len32, par_valid, par_len32, acc_clear;
    logic reverse, pair_a_sel, pair_b_sel, issue_refused, misalign_suppress, result_valid;
    basu_op_t op_kind, result_op;
    logic [2:0] dest0_idx, dest1_idx, unpack_dest0_idx, unpack_dest1_idx;
    logic [31:0] dreg0, dreg1, dreg2, dreg3, unpack_dest0, unpack_dest1;
    logic [1:0] align_index_zero, align_index_one;
    basu_half_t acc_zero_low_half, acc_zero_high_half, acc_one_low_half, acc_one_high_half;
    int fail_count = 0;
    int compares = 0;
    int acc [4] = '{0, 0, 0, 0};
    logic [31:0] rs [4];
    logic [31:0] ed0 = 32'h0000_0000;
    logic [31:0] ed1 = 32'h0000_0000;
    logic [5:0] edx = 6'h00;
    logic pend_v = 1'b0;
    basu_op_t pend_op = BASU_OP_IDLE;
    logic [31:0] seed = 32'h5F6BFD99;
    logic [31:0] rr;

    always #50 clk = ~clk;

    basu_decode_model dec (.clk, .op_kind, .issue_valid, .insn_len32, .par_valid, .par_len32,
        .acc_clear, .reverse, .pair_a_sel, .pair_b_sel, .dest0_idx, .dest1_idx, .dreg0,
        .dreg1, .dreg2, .dreg3, .align_index_zero, .align_index_one);

    basu_unit dut (.clk, .rst_n, .issue_valid, .op_kind, .insn_len32, .reverse, .pair_a_sel,
        .pair_b_sel, .dest0_idx, .dest1_idx, .par_valid, .par_len32, .dreg0, .dreg1, .dreg2,
        .dreg3, .align_index_zero, .align_index_one, .acc_clear, .issue_refused,
        .misalign_suppress, .acc_zero_low_half, .acc_zero_high_half, .acc_one_low_half,
        .acc_one_high_half, .result_valid, .result_op, .unpack_dest0, .unpack_dest1,
        .unpack_dest0_idx, .unpack_dest1_idx);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    function automatic logic [31:0] align(input logic s, input logic r, input logic [1:0] o);
        logic [63:0] w;
        w = r ? {rs[{s, 1'b0}], rs[{s, 1'b1}]} : {rs[{s, 1'b1}], rs[{s, 1'b0}]};
        return w[o*8 +: 32];
    endfunction : align

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // Checks the previous packet's results, then this packet's same-cycle answers
    task automatic op(input basu_op_t k, input logic [7:0] c, input logic [3:0] ix,
            input logic [5:0] dx);
        logic [31:0] a;
        logic [31:0] b;
        logic [15:0] h [4];
        logic ok;
        int m;
        dec.send(k, c, {rs[3], rs[2], rs[1], rs[0]}, ix, dx);
        #10;
        h = '{acc_zero_low_half, acc_zero_high_half, acc_one_low_half, acc_one_high_half};
        check("result_valid", 32'(result_valid), 32'(pend_v));
        check("result_op", 32'(result_op), 32'(pend_op));
        for (int i = 0; i < 4; i++) begin
            check("acc_half", 32'(h[i]), 32'(acc[i]));
        end
        check("unpack_dest0", unpack_dest0, ed0);
        check("unpack_dest1", unpack_dest1, ed1);
        check("unpack_idx", 32'({unpack_dest1_idx, unpack_dest0_idx}), 32'(edx));
        ok = c[7] & c[6] & ~(c[5] & c[4]) & (k != BASU_OP_IDLE);
        check("misalign_suppress", 32'(misalign_suppress), 32'(ok));
        check("issue_refused", 32'(issue_refused), 32'(c[7] & ~ok));
        if (c[3]) begin
            acc = '{0, 0, 0, 0};
        end
        if (ok && k == BASU_OP_SAA) begin
            a = align(c[1], c[2], ix[1:0]);
            b = align(c[0], c[2], ix[3:2]);
            for (int i = 0; i < 4; i++) begin
                m = a[8*i +: 8] - b[8*i +: 8];
                m = (m < 0) ? -m : m;
                acc[i] = (acc[i] + m > 65535) ? 65535 : acc[i] + m;
            end
        end
        if (ok && k == BASU_OP_UNPACK) begin
            a = align(c[1], c[2], ix[1:0]);
            ed0 = {8'h00, a[15:8], 8'h00, a[7:0]};
            ed1 = {8'h00, a[31:24], 8'h00, a[23:16]};
            edx = dx;
        end
        pend_v = ok;
        pend_op = ok ? k : BASU_OP_IDLE;
    endtask : op

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        basu_op_t k;
        logic [7:0] c;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // Known unpack pattern at one byte of offset
        rs = '{32'hBEEFBADD, 32'hFEEDFACE, 32'h0000_0000, 32'h0000_0000};
        op(BASU_OP_UNPACK, 8'hC0, 4'h1, 6'h29);
        op(BASU_OP_IDLE, 8'h00, 4'h0, 6'h00);
        check("unpack_known0", unpack_dest0, 32'h00EF00BA);
        check("unpack_known1", unpack_dest1, 32'h00CE00BE);
        // Every lane differs by 255, so the ceiling is hit after 257 adds
        rs = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0000_0000, 32'h0000_0000};
        for (int i = 0; i < 300; i++) begin
            rr = rnd();
            op(BASU_OP_SAA, {4'hC, (i == 0), rr[0], 2'b01}, rr[5:2], 6'h00);
        end
        // Random mix; a clear rides only with idle or an accepted sum
        for (int i = 0; i < 600; i++) begin
            rr = rnd();
            foreach (rs[j]) begin
                rs[j] = rnd();
            end
            k = (rr[11:10] == 2'b00) ? BASU_OP_IDLE : rr[10] ? BASU_OP_SAA : BASU_OP_UNPACK;
            c = {rr[0] | rr[1], rr[2] | rr[3], rr[8], rr[9], 1'b0, rr[4], rr[5], rr[6]};
            if (rr[15:12] == 4'h0 && (!c[7] || (k == BASU_OP_SAA && c[6] && !(c[5] && c[4]))))
            begin
                c[3] = 1'b1;
            end
            op(k, c, rr[19:16], rr[25:20]);
        end
        op(BASU_OP_IDLE, 8'h00, 4'h0, 6'h00);
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
endmodule : byte_align_sad_unpack_unit_tb
